// ===== port_remap_pkg.sv
// Shared constants for the per-port channel tagging and line monitor block.
package port_remap_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_PORT_SELECT = 8'h4c;
   localparam logic [7:0] OFS_TWELVE_BIT_RAW_INPUT_CHANNEL_TYPE = 8'h71;
   localparam logic [7:0] OFS_CHANNEL_REMAP = 8'h72;
   localparam logic [7:0] OFS_FRAME_LINES_HIGH = 8'h73;
   localparam logic [7:0] OFS_FRAME_LINES_LOW = 8'h74;
   localparam logic [7:0] OFS_LINE_LENGTH_HIGH = 8'h75;
   localparam logic [7:0] OFS_LINE_LENGTH_LOW = 8'h76;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int RAW_CHAN_LSB = 6;
   localparam int RAW_TYPE_LSB = 0;
   localparam int PORT_SEL_BIT = 0;
   localparam logic [5:0] RAW_TYPE_RESET = 6'h2c;
   localparam logic [7:0] CHANNEL_REMAP_RESET = 8'he4;
   localparam logic [7:0] PORT_SELECT_RESET = 8'h00;
   localparam logic [15:0] STAT_RESET = 16'h0000;

   // ------------------------------------------------------------
   // Input mode encodings
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_PACKET = 2'h0;
   localparam logic [1:0] MODE_TWELVE_BIT_RAW_INPUT_50 = 2'h1;
   localparam logic [1:0] MODE_TWELVE_BIT_RAW_INPUT_75 = 2'h2;
   localparam logic [1:0] MODE_TEN_BIT_RAW_INPUT_100 = 2'h3;

   // ------------------------------------------------------------
   // Buffer sizing
   // ------------------------------------------------------------
   localparam int FIFO_DEPTH = 16;

endpackage : port_remap_pkg

// ===== tag_fifo.sv
// Parameterised FIFO with a registered output stage and registered input ready.
`timescale 1ns/1ps

module tag_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);

   localparam int AW = $clog2(DEPTH);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("tag_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic push;
   logic pop;

   // Push is gated by the registered ready; pop refills the output stage.
   assign push = i_in_valid && o_in_ready;
   assign pop = (count_reg != '0) && (!o_out_valid || i_out_ready);
   assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // Storage writes need no reset.
   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_in_data;
      end
   end

   // Pointers, occupancy, ready and the output stage.
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         o_in_ready <= 1'b0;
         o_out_valid <= 1'b0;
         o_out_data <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count_reg <= count_next;
         o_in_ready <= (count_next != (AW+1)'(DEPTH));
         if (pop) begin
            o_out_valid <= 1'b1;
            o_out_data <= mem_reg[rd_ptr_reg];
         end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
         end
      end
   end

endmodule : tag_fifo

// ===== port_vc_remap_line_monitor.sv
// Per-port channel tagging, channel remapping and frame line statistics.
`timescale 1ns/1ps

// Notes on behaviour
// - Register accesses go to the copy of the port chosen by the port select register.
// - Twelve_bit_raw_input channel and type tagging applies only in twelve_bit_raw_input input modes.
// - Twelve_bit_raw_input channel field sits in bits 7:6 and tags twelve_bit_raw_input traffic.
// - Twelve_bit_raw_input channel field resets to the port's own number.
// - Twelve_bit_raw_input type field sits in bits 5:0, resets to 0x2c, tags twelve_bit_raw_input traffic.
// - Channel remapping applies only in packet input mode.
// - Each packet channel is replaced by the two-bit map field its value selects.
// - Remap register resets to 0xe4, an identity mapping.
// - Read-only line count, high and low bytes, of the latest frame.
// - With line count change enable set, the count freezes until software reads it.
// - Reading the line count high byte captures the matching low byte.
// - Read-only line length, high and low bytes, of the latest frame.
// - When line lengths vary, the last line of the frame is reported.
// - With line length change enable set, the length freezes until read.
// - Reading the line length high byte captures the matching low byte.
// - Input mode 00 packet, 01 twelve_bit_raw_input 50 MHz, 10 twelve_bit_raw_input 75 MHz, 11 ten_bit_raw_input.
module port_vc_remap_line_monitor
   import port_remap_pkg::*;
#(
   parameter int NUM_PORTS = 2,
   parameter int DATA_W = 16,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic [2*NUM_PORTS-1:0] i_port_input_mode,
   input wire logic [NUM_PORTS-1:0] i_frame_lines_change_irq_en,
   input wire logic [NUM_PORTS-1:0] i_line_length_change_irq_en,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic i_in_port,
   input wire logic [1:0] i_in_vc,
   input wire logic [5:0] i_in_dt,
   input wire logic [DATA_W-1:0] i_in_data,
   input wire logic i_in_eol,
   input wire logic i_in_eof,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic o_out_port,
   output logic [1:0] o_out_vc,
   output logic [5:0] o_out_dt,
   output logic [DATA_W-1:0] o_out_data
);

   localparam int WORD_W = 1 + 2 + 6 + DATA_W;

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (NUM_PORTS < 1 || NUM_PORTS > 2 || DATA_W < 1) begin : g_bad_param
      $error("port_vc_remap_line_monitor: NUM_PORTS must be 1 or 2");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] port_select_reg;
   logic [7:0] raw_id_reg [NUM_PORTS];
   logic [7:0] remap_reg [NUM_PORTS];
   logic [15:0] lines_rep_reg [NUM_PORTS];
   logic [15:0] len_rep_reg [NUM_PORTS];
   logic [7:0] lines_low_reg [NUM_PORTS];
   logic [7:0] len_low_reg [NUM_PORTS];
   logic [NUM_PORTS-1:0] lines_hold_reg;
   logic [NUM_PORTS-1:0] len_hold_reg;
   logic [15:0] line_cnt_reg [NUM_PORTS];
   logic [15:0] len_cnt_reg [NUM_PORTS];

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   // The select bit picks which port's copy is seen by software.
   wire sel = port_select_reg[PORT_SEL_BIT];
   wire wr_raw = i_reg_wr && (i_reg_addr == OFS_TWELVE_BIT_RAW_INPUT_CHANNEL_TYPE);
   wire wr_remap = i_reg_wr && (i_reg_addr == OFS_CHANNEL_REMAP);
   wire wr_select = i_reg_wr && (i_reg_addr == OFS_PORT_SELECT);
   wire rd_lines_hi = i_reg_rd && (i_reg_addr == OFS_FRAME_LINES_HIGH);
   wire rd_len_hi = i_reg_rd && (i_reg_addr == OFS_LINE_LENGTH_HIGH);

   // Read mux; unmapped addresses read as zero.
   logic [7:0] rd_mux;
   always_comb begin
      case (i_reg_addr)
         OFS_PORT_SELECT: rd_mux = port_select_reg;
         OFS_TWELVE_BIT_RAW_INPUT_CHANNEL_TYPE: rd_mux = raw_id_reg[sel];
         OFS_CHANNEL_REMAP: rd_mux = remap_reg[sel];
         OFS_FRAME_LINES_HIGH: rd_mux = lines_rep_reg[sel][15:8];
         OFS_FRAME_LINES_LOW: rd_mux = lines_low_reg[sel];
         OFS_LINE_LENGTH_HIGH: rd_mux = len_rep_reg[sel][15:8];
         OFS_LINE_LENGTH_LOW: rd_mux = len_low_reg[sel];
         default: rd_mux = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // Data path tagging
   // ------------------------------------------------------------
   // Decode the mode of the beat's port and pick the channel and type.
   wire [1:0] in_mode = i_port_input_mode[2*i_in_port +: 2];
   wire is_packet = (in_mode == MODE_PACKET);
   wire is_twelve_bit_raw_input = (in_mode == MODE_TWELVE_BIT_RAW_INPUT_50) || (in_mode == MODE_TWELVE_BIT_RAW_INPUT_75);
   wire [7:0] in_raw_id = raw_id_reg[i_in_port];
   wire [1:0] remapped_vc = remap_reg[i_in_port][2*i_in_vc +: 2];
   wire [1:0] tag_vc = is_packet ? remapped_vc :
                       is_twelve_bit_raw_input ? in_raw_id[RAW_CHAN_LSB +: 2] : i_in_vc;
   wire [5:0] tag_dt = is_twelve_bit_raw_input ? in_raw_id[RAW_TYPE_LSB +: 6] : i_in_dt;
   wire in_fire = i_in_valid && o_in_ready;
   wire frame_done = in_fire && i_in_eol && i_in_eof;

   logic [WORD_W-1:0] fifo_out;

   tag_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(DEPTH)
   ) tag_fifo_inst (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_in_valid(i_in_valid),
      .o_in_ready(o_in_ready),
      .i_in_data({i_in_port, tag_vc, tag_dt, i_in_data}),
      .o_out_valid(o_out_valid),
      .i_out_ready(i_out_ready),
      .o_out_data(fifo_out)
   );

   // Unpack the registered FIFO output word.
   assign o_out_port = fifo_out[WORD_W-1];
   assign o_out_vc = fifo_out[WORD_W-2 -: 2];
   assign o_out_dt = fifo_out[WORD_W-4 -: 6];
   assign o_out_data = fifo_out[DATA_W-1:0];

   // ------------------------------------------------------------
   // Port select and read data
   // ------------------------------------------------------------
   // Port select register and the registered read answer.
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         port_select_reg <= PORT_SELECT_RESET;
         o_reg_rdata <= 8'h00;
      end else begin
         if (wr_select) begin
            port_select_reg <= i_reg_wdata;
         end
         if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------
   // Per-port configuration and statistics
   // ------------------------------------------------------------
   // Each port keeps its own settings, counters and frozen report.
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            raw_id_reg[p] <= {p[1:0], RAW_TYPE_RESET};
            remap_reg[p] <= CHANNEL_REMAP_RESET;
            lines_rep_reg[p] <= STAT_RESET;
            len_rep_reg[p] <= STAT_RESET;
            lines_low_reg[p] <= 8'h00;
            len_low_reg[p] <= 8'h00;
            line_cnt_reg[p] <= STAT_RESET;
            len_cnt_reg[p] <= STAT_RESET;
         end
         lines_hold_reg <= '0;
         len_hold_reg <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_raw && sel == p[0]) begin
               raw_id_reg[p] <= i_reg_wdata;
            end
            if (wr_remap && sel == p[0]) begin
               remap_reg[p] <= i_reg_wdata;
            end
            // The high-byte read captures the low byte of the same value.
            if (rd_lines_hi && sel == p[0]) begin
               lines_low_reg[p] <= lines_rep_reg[p][7:0];
            end
            if (rd_len_hi && sel == p[0]) begin
               len_low_reg[p] <= len_rep_reg[p][7:0];
            end
            // Running counters; the length stops one short of all ones so the reported length never wraps.
            if (in_fire && i_in_port == p[0]) begin
               if (i_in_eol) begin
                  len_cnt_reg[p] <= STAT_RESET;
                  line_cnt_reg[p] <= i_in_eof ? STAT_RESET : line_cnt_reg[p] + 16'h0001;
               end else if (len_cnt_reg[p] != 16'hfffe) begin
                  len_cnt_reg[p] <= len_cnt_reg[p] + 16'h0001;
               end
            end
            // Line count report; an update wins over a same-cycle read.
            if (frame_done && i_in_port == p[0] &&
                !(i_frame_lines_change_irq_en[p] && lines_hold_reg[p])) begin
               lines_rep_reg[p] <= line_cnt_reg[p] + 16'h0001;
               lines_hold_reg[p] <= i_frame_lines_change_irq_en[p];
            end else if ((rd_lines_hi && sel == p[0]) || !i_frame_lines_change_irq_en[p]) begin
               lines_hold_reg[p] <= 1'b0;
            end
            // Line length report: the length of the frame's final line.
            if (frame_done && i_in_port == p[0] &&
                !(i_line_length_change_irq_en[p] && len_hold_reg[p])) begin
               len_rep_reg[p] <= len_cnt_reg[p] + 16'h0001;
               len_hold_reg[p] <= i_line_length_change_irq_en[p];
            end else if ((rd_len_hi && sel == p[0]) || !i_line_length_change_irq_en[p]) begin
               len_hold_reg[p] <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   wire [15:0] in_lines = lines_rep_reg[i_in_port];
   wire [15:0] in_len = len_rep_reg[i_in_port];
   wire lines_frozen = i_frame_lines_change_irq_en[i_in_port] && lines_hold_reg[i_in_port];
   wire len_frozen = i_line_length_change_irq_en[i_in_port] && len_hold_reg[i_in_port];

   // A remap write lands in the selected port's copy.
   property p_select_route;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      wr_remap |=> remap_reg[$past(sel)] == $past(i_reg_wdata);
   endproperty
   a_select_route: assert property (p_select_route) else $error("remap write missed the selected port");

   // Twelve_bit_raw_input beats carry the configured channel and type into the FIFO.
   property p_raw_tag;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (in_fire && is_twelve_bit_raw_input) |-> (tag_vc == raw_id_reg[i_in_port][7:6]) && (tag_dt == raw_id_reg[i_in_port][5:0]);
   endproperty
   a_raw_tag: assert property (p_raw_tag) else $error("twelve_bit_raw_input tag mismatch");

   // Outside twelve_bit_raw_input modes the type passes unchanged.
   property p_raw_only;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (in_fire && !is_twelve_bit_raw_input) |-> tag_dt == i_in_dt;
   endproperty
   a_raw_only: assert property (p_raw_only) else $error("type altered outside twelve_bit_raw_input");

   // Packet beats with an identity map keep their channel.
   property p_remap_identity;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (in_fire && is_packet && remap_reg[i_in_port] == CHANNEL_REMAP_RESET) |-> tag_vc == i_in_vc;
   endproperty
   a_remap_identity: assert property (p_remap_identity) else $error("identity remap changed channel");

   // Reading the twelve_bit_raw_input register returns the selected copy one cycle later.
   property p_readback;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_reg_rd && i_reg_addr == OFS_TWELVE_BIT_RAW_INPUT_CHANNEL_TYPE && !i_reg_wr) |=> o_reg_rdata == $past(raw_id_reg[sel]);
   endproperty
   a_readback: assert property (p_readback) else $error("twelve_bit_raw_input readback wrong");

   // A frame end without freezing reports the count of its lines.
   property p_lines_update;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (frame_done && !lines_frozen) |=> lines_rep_reg[$past(i_in_port)] == $past(line_cnt_reg[i_in_port]) + 16'h0001;
   endproperty
   a_lines_update: assert property (p_lines_update) else $error("line count not updated");

   // A frozen count stays put through a frame end; the port is taken from the frame's last beat.
   property p_lines_freeze;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (frame_done && lines_frozen) |=> (lines_rep_reg[$past(i_in_port)] == $past(in_lines)) &&
         (lines_hold_reg[$past(i_in_port)] || $past(rd_lines_hi && sel == i_in_port));
   endproperty
   a_lines_freeze: assert property (p_lines_freeze) else $error("frozen line count moved");

   // The high-byte read latches the matching low byte.
   property p_lines_latch;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      rd_lines_hi |=> lines_low_reg[$past(sel)] == $past(lines_rep_reg[sel][7:0]);
   endproperty
   a_lines_latch: assert property (p_lines_latch) else $error("line count low byte not latched");

   // The reported length is that of the frame's last line.
   property p_len_last;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (frame_done && !len_frozen) |=> len_rep_reg[$past(i_in_port)] == $past(len_cnt_reg[i_in_port]) + 16'h0001;
   endproperty
   a_len_last: assert property (p_len_last) else $error("line length not of last line");

   // A frozen length stays put through a frame end.
   property p_len_freeze;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (frame_done && len_frozen) |=> len_rep_reg[$past(i_in_port)] == $past(in_len);
   endproperty
   a_len_freeze: assert property (p_len_freeze) else $error("frozen line length moved");

   // The length high-byte read latches the matching low byte.
   property p_len_latch;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      rd_len_hi |=> len_low_reg[$past(sel)] == $past(len_rep_reg[sel][7:0]);
   endproperty
   a_len_latch: assert property (p_len_latch) else $error("line length low byte not latched");

   // Main scenarios.
   property p_cov_raw;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      in_fire && is_twelve_bit_raw_input;
   endproperty
   c_cov_raw: cover property (p_cov_raw);

   property p_cov_remap;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      in_fire && is_packet && tag_vc != i_in_vc;
   endproperty
   c_cov_remap: cover property (p_cov_remap);

   property p_cov_freeze;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      frame_done && lines_frozen;
   endproperty
   c_cov_freeze: cover property (p_cov_freeze);

   property p_cov_full;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_in_valid && !o_in_ready;
   endproperty
   c_cov_full: cover property (p_cov_full);

endmodule : port_vc_remap_line_monitor

// ===== sensor_source_model.sv
// Behavioural model of the remote serializer that feeds tagged beats into the block.
`timescale 1ns/1ps

module sensor_source_model (
   input wire logic i_ref_clk,
   input wire logic i_ready,
   output logic o_valid,
   output logic o_port,
   output logic [1:0] o_vc,
   output logic [5:0] o_dt,
   output logic [15:0] o_data,
   output logic o_eol,
   output logic o_eof
);
   // Lines start quiet; released lines are scrambled so a stale beat never looks fresh.
   initial begin
      o_valid = 1'b0;
      o_port = 1'b0;
      o_vc = 2'h0;
      o_dt = 6'h00;
      o_data = 16'h0000;
      o_eol = 1'b0;
      o_eof = 1'b0;
   end

   // Presents one beat and holds it until the edge that samples ready high.
   task automatic send(input logic p, input logic [1:0] vc, input logic [5:0] dt, input logic [15:0] d,
                       input logic eol, input logic eof);
      int n;
      n = 0;
      o_port = p;
      o_vc = vc;
      o_dt = dt;
      o_data = d;
      o_eol = eol;
      o_eof = eof;
      o_valid = 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (i_ready !== 1'b1 && n < 4000);
      #1;
   endtask : send

   // Withdraws the beat and inverts every line it released.
   task automatic idle();
      o_valid = 1'b0;
      o_port = ~o_port;
      o_vc = ~o_vc;
      o_dt = ~o_dt;
      o_data = ~o_data;
      o_eol = ~o_eol;
      o_eof = ~o_eof;
   endtask : idle
endmodule : sensor_source_model

// ===== tb_port_vc_remap_line_monitor.sv
// Self-checking testbench for the channel tagging and line statistics block.
`timescale 1ns/1ps

module tb_port_vc_remap_line_monitor;
   import port_remap_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [3:0] port_mode = 4'h0;
   logic [1:0] lines_en = 2'h0;
   logic [1:0] len_en = 2'h0;
   logic in_valid, in_ready, in_port, in_eol, in_eof, out_valid, out_port;
   logic out_ready = 1'b1;
   logic [1:0] in_vc, out_vc;
   logic [5:0] in_dt, out_dt;
   logic [15:0] in_data, out_data;
   logic [7:0] raw_reg [2];
   logic [7:0] map_reg [2];
   logic [24:0] exp_q [$];
   logic [24:0] exp_beat;
   int mismatches = 0;
   int n_compared = 0;
   int m, p, v, n;

   // The clock toggles every half period of 2.5 ns.
   always #2.5 ref_clk = ~ref_clk;

   port_vc_remap_line_monitor #(.NUM_PORTS(2), .DATA_W(16), .DEPTH(FIFO_DEPTH)) port_vc_remap_line_monitor_inst (
      .i_ref_clk(ref_clk), .i_rstn(rstn), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_port_input_mode(port_mode),
      .i_frame_lines_change_irq_en(lines_en), .i_line_length_change_irq_en(len_en),
      .i_in_valid(in_valid), .o_in_ready(in_ready), .i_in_port(in_port), .i_in_vc(in_vc), .i_in_dt(in_dt),
      .i_in_data(in_data), .i_in_eol(in_eol), .i_in_eof(in_eof), .o_out_valid(out_valid),
      .i_out_ready(out_ready), .o_out_port(out_port), .o_out_vc(out_vc), .o_out_dt(out_dt),
      .o_out_data(out_data));

   sensor_source_model sensor_source_model_inst (
      .i_ref_clk(ref_clk), .i_ready(in_ready), .o_valid(in_valid), .o_port(in_port), .o_vc(in_vc),
      .o_dt(in_dt), .o_data(in_data), .o_eol(in_eol), .o_eof(in_eof));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Counts a comparison and reports a difference at once.
   task automatic check(input string name, input logic [24:0] seen, input logic [24:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   // Prints the verdict and ends the run.
   task automatic summarize();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   // One write strobe, launched just after an edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr

   // One read strobe; the answer is taken one cycle after the read edge.
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      @(posedge ref_clk);
      #1;
      check(name, {17'h0, reg_rdata}, {17'h0, exp});
   endtask : rdc

   // Expected output beat: packet mode remaps, twelve_bit_raw_input modes retag, ten_bit_raw_input passes through.
   function automatic logic [24:0] expect_beat(logic p, logic [1:0] vc, logic [5:0] dt, logic [15:0] d);
      logic [1:0] md;
      md = port_mode[2*p+:2];
      if (md == MODE_PACKET) begin
         vc = map_reg[p][2*vc+:2];
      end else if (md != MODE_TEN_BIT_RAW_INPUT_100) begin
         vc = raw_reg[p][7:6];
         dt = raw_reg[p][5:0];
      end
      return {p, vc, dt, d};
   endfunction : expect_beat

   // Queues the expectation and hands the beat to the source model.
   task automatic beat(input logic p, input logic [1:0] vc, input logic [5:0] dt, input logic [15:0] d,
                       input logic eol, input logic eof);
      exp_q.push_back(expect_beat(p, vc, dt, d));
      sensor_source_model_inst.send(p, vc, dt, d, eol, eof);
   endtask : beat

   // Sends a frame of one or two lines on port 0; a zero second length means one line.
   task automatic frame(input int a, input int b);
      int len;
      @(posedge ref_clk);
      #1;
      for (int ln = 0; ln < 2; ln++) begin
         len = (ln == 0) ? a : b;
         for (int w = 0; w < len; w++) begin
            beat(1'b0, 2'h0, 6'h2a, w[15:0], w == len - 1, (w == len - 1) && (ln == 1 || b == 0));
         end
      end
      sensor_source_model_inst.idle();
   endtask : frame

   // Waits, bounded, until every queued beat has come out.
   task automatic drain();
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (exp_q.size() != 0 && n < 2000);
      #1;
      check("queue_left", 25'(exp_q.size()), 25'h0);
   endtask : drain

   // Scoreboard: every beat handed over must match the next expectation, in order.
   always @(posedge ref_clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         exp_beat = (exp_q.size() != 0) ? exp_q.pop_front() : 25'h1ffffff;
         check("out_beat", {out_port, out_vc, out_dt, out_data}, exp_beat);
      end
   end

   // Cuts a hang short well beyond the expected run of under a thousand cycles.
   initial begin
      #100000;
      mismatches++;
      summarize();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      raw_reg = '{8'h2c, 8'h6c};
      map_reg = '{8'he4, 8'he4};
      repeat (2) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      repeat (2) @(posedge ref_clk);
      rdc(OFS_TWELVE_BIT_RAW_INPUT_CHANNEL_TYPE, 8'h2c, "raw_port0");
      rdc(OFS_CHANNEL_REMAP, 8'he4, "remap_port0");
      for (int a = 8'h73; a <= 8'h76; a++) rdc(a[7:0], 8'h00, "stat_reset");
      rdc(8'h70, 8'h00, "unmapped");
      wr(OFS_PORT_SELECT, 8'h01);
      rdc(OFS_PORT_SELECT, 8'h01, "port_select");
      rdc(OFS_TWELVE_BIT_RAW_INPUT_CHANNEL_TYPE, 8'h6c, "raw_port1");
      wr(OFS_TWELVE_BIT_RAW_INPUT_CHANNEL_TYPE, 8'h95);
      wr(OFS_CHANNEL_REMAP, 8'h1b);
      wr(OFS_FRAME_LINES_HIGH, 8'h5a);
      raw_reg[1] = 8'h95;
      map_reg[1] = 8'h1b;
      rdc(OFS_CHANNEL_REMAP, 8'h1b, "remap_port1");
      rdc(OFS_FRAME_LINES_HIGH, 8'h00, "ro_write");
      wr(OFS_PORT_SELECT, 8'h00);
      rdc(OFS_TWELVE_BIT_RAW_INPUT_CHANNEL_TYPE, 8'h2c, "raw_port0_kept");
      // Every mode, both ports, every incoming channel, back to back.
      for (m = 0; m < 4; m++) begin
         port_mode = {m[1:0], m[1:0]};
         for (p = 0; p < 2; p++) for (v = 0; v < 4; v++) beat(p[0], v[1:0], 6'h12, 16'(16'h0100 * m + 16 * p + v), 1'b0, 1'b0);
         sensor_source_model_inst.idle();
         drain();
      end
      // Fill the buffer with the sink stalled, then drain it with a stuttering sink.
      out_ready = 1'b0;
      for (v = 0; v < 17; v++) beat(1'b0, 2'h1, 6'h05, 16'(16'h0a00 + v), 1'b0, 1'b0);
      sensor_source_model_inst.idle();
      repeat (2) @(posedge ref_clk);
      #1;
      check("in_ready_full", {24'h0, in_ready}, 25'h0);
      for (n = 0; n < 200 && exp_q.size() != 0; n++) begin
         @(posedge ref_clk);
         #1;
         out_ready = ~out_ready;
      end
      out_ready = 1'b1;
      drain();
      // Frozen statistics, then unfrozen ones with a 16-bit length.
      port_mode = 4'h0;
      lines_en = 2'h1;
      len_en = 2'h1;
      frame(260, 3);
      frame(5, 0);
      rdc(OFS_FRAME_LINES_HIGH, 8'h00, "lines_hi_frozen");
      rdc(OFS_FRAME_LINES_LOW, 8'h02, "lines_lo_frozen");
      rdc(OFS_LINE_LENGTH_HIGH, 8'h00, "len_hi_frozen");
      rdc(OFS_LINE_LENGTH_LOW, 8'h03, "len_lo_frozen");
      lines_en = 2'h0;
      len_en = 2'h0;
      frame(2, 260);
      rdc(OFS_FRAME_LINES_HIGH, 8'h00, "lines_hi");
      rdc(OFS_LINE_LENGTH_HIGH, 8'h01, "len_hi");
      frame(1, 0);
      rdc(OFS_FRAME_LINES_LOW, 8'h02, "lines_lo_latched");
      rdc(OFS_LINE_LENGTH_LOW, 8'h04, "len_lo_latched");
      drain();
      summarize();
   end
endmodule : tb_port_vc_remap_line_monitor
